// ===== core/i2c_cond_pkg.sv
// shared constants for the two ends of the sensor serial link
// Overview of operation
// R1: hs command byte unacked, switches fast filters
// R2: master sends target address after hs command
// R3: hs filters kept until stop restores them
// R4: acknowledge general call write address
// R5: ack second general call byte, nack rest
// R6: general call read returns pointed word
// R7: pointer selects temperature after reset
// R8: scl low timeout resets interface, frees sda
// R9: after timeout wait for fresh start
// R10: master clocks faster than timeout rate
// R11: start is sda falling with scl high
// R12: stop is sda rising; start/stop end transfers
// R13: no limit on bytes per transfer
// R14: start or stop abandons low byte cleanly
// R15: ack holds sda low through ack high
// R16: master nack ends read, device releases
// R17: idle releases sda; scl never driven
// R18: address select pin picks lower/upper address
// R19: reads use last written pointer, retained
// R20: filtered sampled edges, depth follows hs flag
// R21: nack addresses not matching own/general
package i2c_cond_pkg;
	localparam int        CLK_HZ        = 100_000_000;
	localparam int        TIMEOUT_MS    = 30;
	localparam longint    TIMEOUT_CYC_L = longint'(CLK_HZ) / 1000 * TIMEOUT_MS;
	localparam int        TIMEOUT_CYC   = int'(TIMEOUT_CYC_L);
	localparam logic [6:0] ADDR_LOW     = 7'h48;
	localparam logic [6:0] ADDR_HIGH    = 7'h49;
	localparam logic [6:0] ADDR_GENERAL = 7'h00;
	localparam logic [4:0] HS_PATTERN   = 5'h01;
	localparam logic [7:0] PTR_TEMP     = 8'h00;
	localparam int        FILT_SLOW     = 4;
	localparam int        FILT_FAST     = 1;
	localparam int        HALF_DIV      = 8;
	localparam logic [7:0] RD_BIT       = 8'h01;
endpackage

// ===== core/i2c_cond_if.sv
`timescale 1ns/1ns
// open-drain link between bus master and sensor target
interface i2c_cond_if;
	logic scl_m_oe;
	logic sda_m_oe;
	logic sda_d_oe;
	logic scl;
	logic sda;
	assign scl = ~scl_m_oe;
	assign sda = ~(sda_m_oe | sda_d_oe);
	modport target (input scl, input sda, output sda_d_oe);
	modport master (input scl, input sda, output scl_m_oe, output sda_m_oe);
endinterface

// ===== core/byte_fifo.sv
`timescale 1ns/1ns
// small valid/ready fifo
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	// fill side
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	// drain side
	output logic                  out_valid_out,
	output logic      [WIDTH-1:0] out_data_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;
	logic             push;
	logic             pop;
	logic [AW:0]      level_d;
	// occupancy after this edge's push and pop
	assign level_d       = wr_q - rd_q + (AW+1)'(push) - (AW+1)'(pop);
	assign out_valid_out = wr_q != rd_q;
	assign out_data_out  = mem_q[rd_q[AW-1:0]];
	assign push = in_valid_in & in_ready_out;
	assign pop  = out_valid_out & out_ready_in;
	// storage
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data_in;
		end
	end
	// registered room flag, so the ready output comes from a flop
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			in_ready_out <= 1'b1;
		end else begin
			in_ready_out <= level_d != (AW+1)'(DEPTH);
		end
	end
	// pointers
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule

// ===== core/i2c_target.sv
`timescale 1ns/1ns
// sensor-side target: conditions, acks, hs mode, general call, timeout
module i2c_target #(
	parameter int TIMEOUT_CYC = i2c_cond_pkg::TIMEOUT_CYC
) (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// link
	i2c_cond_if.target       bus,
	// straps and register data
	input  wire logic        address_select_pin_in,
	input  wire logic [15:0] reg_word_in,
	// user side
	output logic [7:0]       pointer_out,
	output logic             wr_valid_out,
	output logic [7:0]       wr_data_out,
	input  wire logic        wr_ready_in,
	output logic             hs_mode_out,
	output logic             timeout_out
);
	typedef enum {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_MACK} state_t;
	typedef enum {K_NONE, K_WR, K_RD, K_GC} kind_t;
	logic [1:0] scl_s_q, sda_s_q;
	logic       scl_f_q, sda_f_q, scl_p_q, sda_p_q;
	logic [2:0] fcnt_scl_q, fcnt_sda_q;
	state_t     st_q;
	kind_t      kind_q;
	logic [7:0] sh_q;
	logic [3:0] bit_q;
	logic [2:0] byte_q;
	logic       ack_q, sda_oe_q, hs_q, to_q, wv_q;
	logic [7:0] ptr_q, wd_q;
	logic [15:0] tx_q;
	logic [6:0] my_addr_q;
	logic [$clog2(TIMEOUT_CYC+1)-1:0] low_q;
	logic       start, stop, rise, fall;
	logic [2:0] depth;
	logic       ack_d;
	logic [1:0] addr_s_q;
	// synchronise pins, then filter with hs-dependent depth
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			scl_s_q <= 2'h3;
			sda_s_q <= 2'h3;
		end else begin
			scl_s_q <= {scl_s_q[0], bus.scl};
			sda_s_q <= {sda_s_q[0], bus.sda};
		end
	end
	assign depth = hs_q ? 3'(i2c_cond_pkg::FILT_FAST) : 3'(i2c_cond_pkg::FILT_SLOW); // [R20] [R1]
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			scl_f_q    <= 1'b1;
			sda_f_q    <= 1'b1;
			fcnt_scl_q <= '0;
			fcnt_sda_q <= '0;
		end else begin
			if (scl_s_q[1] == scl_f_q) begin
				fcnt_scl_q <= '0;
			end else if (fcnt_scl_q + 3'h1 >= depth) begin
				scl_f_q    <= scl_s_q[1];
				fcnt_scl_q <= '0;
			end else begin
				fcnt_scl_q <= fcnt_scl_q + 3'h1;
			end
			if (sda_s_q[1] == sda_f_q) begin
				fcnt_sda_q <= '0;
			end else if (fcnt_sda_q + 3'h1 >= depth) begin
				sda_f_q    <= sda_s_q[1];
				fcnt_sda_q <= '0;
			end else begin
				fcnt_sda_q <= fcnt_sda_q + 3'h1;
			end
		end
	end
	// edge and condition detection on filtered lines
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_f_q;
			sda_p_q <= sda_f_q;
		end
	end
	assign start = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q; // [R11]
	assign stop  = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q; // [R12]
	assign rise  = scl_f_q & ~scl_p_q;
	assign fall  = ~scl_f_q & scl_p_q;
	// address strap pin through two flops before use
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			addr_s_q <= 2'h0;
		end else begin
			addr_s_q <= {addr_s_q[0], address_select_pin_in};
		end
	end
	// own address picked by the synchronised strap
	always_ff @(posedge clk_in) begin
		my_addr_q <= addr_s_q[1] ? i2c_cond_pkg::ADDR_HIGH
			: i2c_cond_pkg::ADDR_LOW; // [R18]
	end
	// scl low timeout counter
	always_ff @(posedge clk_in) begin
		if (rst_in || scl_f_q) low_q <= '0;
		else if (low_q != ($bits(low_q))'(TIMEOUT_CYC)) low_q <= low_q + 1'b1;
	end
	// hs filter mode
	always_ff @(posedge clk_in) begin
		if (rst_in || stop) hs_q <= 1'b0; // [R3]
		else if (st_q == ST_ADDR && rise && bit_q == 4'd7 && byte_q == 3'd0
			&& sh_q[6:2] == i2c_cond_pkg::HS_PATTERN) hs_q <= 1'b1; // [R1]
	end
	// acknowledge decision for the byte just shifted in
	always_comb begin
		ack_d = 1'b0;
		if (st_q == ST_ADDR) begin
			ack_d = sh_q[7:1] == my_addr_q // [R21]
				|| sh_q[7:1] == i2c_cond_pkg::ADDR_GENERAL; // [R4] [R6]
		end else if (kind_q == K_GC) begin
			ack_d = byte_q == 3'd1; // [R5]
		end else begin
			ack_d = 1'b1; // [R13]
		end
	end
	// protocol engine; ack driven from the fall after bit 8 so it covers the 9th clock
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_q     <= ST_IDLE;
			kind_q   <= K_NONE;
			sh_q     <= '0;
			bit_q    <= '0;
			byte_q   <= '0;
			ack_q    <= 1'b0;
			sda_oe_q <= 1'b0;
			ptr_q    <= i2c_cond_pkg::PTR_TEMP; // [R7]
			tx_q     <= '0;
			to_q     <= 1'b0;
			wv_q     <= 1'b0;
			wd_q     <= '0;
		end else begin
			wv_q <= wv_q & ~wr_ready_in;
			if (low_q == ($bits(low_q))'(TIMEOUT_CYC) && st_q != ST_IDLE) begin
				st_q     <= ST_IDLE; // [R8] [R9]
				sda_oe_q <= 1'b0;
				to_q     <= 1'b1;
			end else if (start) begin
				st_q     <= ST_ADDR; // [R12] [R14]
				bit_q    <= '0;
				byte_q   <= '0;
				sda_oe_q <= 1'b0;
				to_q     <= 1'b0;
				kind_q   <= K_NONE;
			end else if (stop) begin
				st_q     <= ST_IDLE; // [R12] [R17]
				sda_oe_q <= 1'b0;
			end else if (rise && (st_q == ST_ADDR || st_q == ST_RX)) begin
				sh_q  <= {sh_q[6:0], sda_f_q};
				bit_q <= bit_q + 4'h1;
			end else if (rise && st_q == ST_MACK) begin
				ack_q <= ~sda_f_q; // master ack taken while scl is high [R16]
			end else if (fall) begin
				unique case (st_q)
				ST_IDLE: begin
				end
				ST_ADDR, ST_RX: begin
					if (bit_q == 4'd8) begin
						bit_q    <= '0;
						ack_q    <= ack_d;
						sda_oe_q <= ack_d; // [R15]
						st_q     <= ST_ACK;
						if (byte_q != 3'd7) begin
							byte_q <= byte_q + 3'h1;
						end
						if (st_q == ST_ADDR) begin
							kind_q <= sh_q[0] ? K_RD
								: (sh_q[7:1] == my_addr_q ? K_WR : K_GC);
						end else if (kind_q == K_WR && byte_q == 3'd1) begin
							ptr_q <= sh_q; // [R19]
						end else if (kind_q == K_WR && (!wv_q || wr_ready_in)) begin
							wv_q <= 1'b1; // new byte wins over the clear
							wd_q <= sh_q;
						end
					end
				end
				ST_ACK: begin
					sda_oe_q <= 1'b0;
					if (!ack_q) begin
						st_q <= ST_IDLE; // [R1] [R5] [R21]
					end else if (kind_q == K_RD) begin
						st_q     <= ST_TX; // [R6] [R19]
						sda_oe_q <= ~reg_word_in[15];
						tx_q     <= {reg_word_in[14:0], 1'b0};
						bit_q    <= 4'h1;
					end else begin
						st_q <= ST_RX;
					end
				end
				ST_TX: begin
					if (bit_q == 4'd8) begin
						sda_oe_q <= 1'b0; // line free for the master ack
						bit_q    <= '0;
						st_q     <= ST_MACK;
					end else begin
						sda_oe_q <= ~tx_q[15];
						tx_q     <= {tx_q[14:0], 1'b0};
						bit_q    <= bit_q + 4'h1;
					end
				end
				ST_MACK: begin
					if (ack_q) begin
						st_q     <= ST_TX;
						sda_oe_q <= ~tx_q[15];
						tx_q     <= {tx_q[14:0], 1'b0};
						bit_q    <= 4'h1;
					end else begin
						st_q <= ST_IDLE; // [R16]
					end
				end
				endcase
			end
		end
	end
	// outputs
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			bus.sda_d_oe <= 1'b0;
			pointer_out  <= i2c_cond_pkg::PTR_TEMP;
			wr_valid_out <= 1'b0;
			wr_data_out  <= '0;
			hs_mode_out  <= 1'b0;
			timeout_out  <= 1'b0;
		end else begin
			bus.sda_d_oe <= sda_oe_q & ~start & ~stop; // [R17]
			pointer_out  <= ptr_q;
			wr_valid_out <= wv_q & ~wr_ready_in;
			wr_data_out  <= wd_q;
			hs_mode_out  <= hs_q;
			timeout_out  <= to_q;
		end
	end
endmodule

// ===== core/i2c_master.sv
`timescale 1ns/1ns
// bus master end: byte commands from a fifo, scl by divider
module i2c_master #(
	parameter int HALF_DIV = i2c_cond_pkg::HALF_DIV
) (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// link
	i2c_cond_if.master       bus,
	// command stream: {start, stop, byte}
	input  wire logic        cmd_valid_in,
	input  wire logic [9:0]  cmd_in,
	output logic             cmd_ready_out,
	// result
	output logic             done_out,
	output logic             acked_out,
	output logic [7:0]       rd_data_out
);
	typedef enum {M_IDLE, M_START, M_BITS, M_STOP} mstate_t;
	mstate_t     st_q;
	logic        f_valid, f_take;
	logic [9:0]  f_data;
	logic [9:0]  cmd_q;
	logic [7:0]  div_q, rx_q;
	logic [3:0]  bit_q;
	logic [1:0]  ph_q;
	logic [1:0]  sda_s_q;
	logic        scl_oe_q, sda_oe_q, done_q, ack_q;
	logic        tick, rd;
	byte_fifo #(.WIDTH(10), .DEPTH(8)) u_fifo (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.in_valid_in   (cmd_valid_in),
		.in_data_in    (cmd_in),
		.in_ready_out  (cmd_ready_out),
		.out_valid_out (f_valid),
		.out_data_out  (f_data),
		.out_ready_in  (f_take)
	);
	assign tick   = div_q == 8'(HALF_DIV - 1);
	assign f_take = st_q == M_IDLE && tick && f_valid;
	assign rd     = cmd_q[7:0] == 8'hFF;
	// quarter-phase divider
	always_ff @(posedge clk_in) begin
		if (rst_in || tick) div_q <= '0;
		else div_q <= div_q + 8'h1;
	end
	// sda sampler
	always_ff @(posedge clk_in) begin
		if (rst_in) sda_s_q <= 2'h3;
		else sda_s_q <= {sda_s_q[0], bus.sda};
	end
	// bit engine; byte FF sent as released line means a read byte
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_q <= M_IDLE; cmd_q <= '0; bit_q <= '0; ph_q <= '0; rx_q <= '0;
			scl_oe_q <= 1'b0; sda_oe_q <= 1'b0; done_q <= 1'b0; ack_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (tick) begin
				ph_q <= ph_q + 2'h1;
				unique case (st_q)
				M_IDLE: if (f_valid) begin
					cmd_q <= f_data; ph_q <= '0;
					st_q <= f_data[9] ? M_START : M_BITS; // [R11] [R2]
					bit_q <= '0;
				end
				M_START: unique case (ph_q)
					2'd0: begin scl_oe_q <= 1'b0; sda_oe_q <= 1'b0; end
					2'd1: sda_oe_q <= 1'b1; // [R11]
					2'd2: scl_oe_q <= 1'b1;
					default: begin st_q <= M_BITS; ph_q <= '0; end
				endcase
				M_BITS: unique case (ph_q)
					2'd0: sda_oe_q <= bit_q == 4'd8 ? (rd & ~cmd_q[8]) // [R16]
						: ~cmd_q[7 - 3'(bit_q)];
					2'd1: scl_oe_q <= 1'b0; // [R10]
					2'd2: if (bit_q == 4'd8) ack_q <= ~sda_s_q[1];
						else rx_q <= {rx_q[6:0], sda_s_q[1]};
					default: begin
						scl_oe_q <= 1'b1;
						if (bit_q == 4'd8) begin
							sda_oe_q <= 1'b0; done_q <= 1'b1;
							st_q <= cmd_q[8] ? M_STOP : M_IDLE;
						end else bit_q <= bit_q + 4'h1;
					end
				endcase
				M_STOP: unique case (ph_q)
					2'd0: sda_oe_q <= 1'b1;
					2'd1: scl_oe_q <= 1'b0;
					2'd2: sda_oe_q <= 1'b0; // [R12]
					default: st_q <= M_IDLE;
				endcase
			endcase
			end
		end
	end
	// registered outputs
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			bus.scl_m_oe <= 1'b0; bus.sda_m_oe <= 1'b0;
			done_out <= 1'b0; acked_out <= 1'b0; rd_data_out <= '0;
		end else begin
			bus.scl_m_oe <= scl_oe_q; bus.sda_m_oe <= sda_oe_q;
			done_out <= done_q; acked_out <= ack_q; rd_data_out <= rx_q;
		end
	end
endmodule

// ===== test/i2c_cond_asserts.sv
// concurrent checks on the sensor link and target flags
`timescale 1ns/1ns
module i2c_cond_asserts #(
	parameter int TIMEOUT_CYC = 2000
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// link and target flags
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_d_oe,
	input wire logic hs_mode_out,
	input wire logic timeout_out
);
	logic       scl_q;
	logic       sda_q;
	logic [4:0] stop_q;
	logic [4:0] start_q;
	int         low_q;
	logic       start_w;
	logic       stop_w;
	// start and stop seen on the wire
	assign start_w = scl & scl_q & sda_q & ~sda;
	assign stop_w  = scl & scl_q & ~sda_q & sda;
	// line history, condition ages, scl low time
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			scl_q   <= 1'h1;
			sda_q   <= 1'h1;
			stop_q  <= 5'h1F;
			start_q <= 5'h1F;
			low_q   <= 0;
		end else begin
			scl_q   <= scl;
			sda_q   <= sda;
			stop_q  <= stop_w ? 5'h00 : stop_q + 5'(stop_q != 5'h1F);
			start_q <= start_w ? 5'h00 : start_q + 5'(start_q != 5'h1F);
			low_q   <= scl ? 0 : low_q + 1;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	property p_stop_free; stop_w |-> !sda_d_oe [*8]; endproperty
	property p_start_free; start_w |-> !sda_d_oe [*8]; endproperty
	property p_hs_exit; stop_w |-> ##[1:24] !hs_mode_out; endproperty
	property p_hs_keep; $fell(hs_mode_out) |-> stop_q < 5'h18; endproperty
	property p_to_late; $rose(timeout_out) |-> low_q >= TIMEOUT_CYC - 2; endproperty
	property p_to_due; low_q == TIMEOUT_CYC + 24 |-> timeout_out; endproperty
	property p_to_free; timeout_out |-> !sda_d_oe; endproperty
	property p_to_clear; $fell(timeout_out) |-> start_q < 5'h18; endproperty
	property p_ack_steady; scl && scl_q |-> $stable(sda_d_oe); endproperty
	a_stop_free: assert property (p_stop_free)
		else $error("sda driven after stop");
	a_start_free: assert property (p_start_free)
		else $error("sda driven after start");
	a_hs_exit: assert property (p_hs_exit)
		else $error("hs kept after stop");
	a_hs_keep: assert property (p_hs_keep)
		else $error("hs dropped without stop");
	a_to_late: assert property (p_to_late)
		else $error("timeout too early");
	a_to_due: assert property (p_to_due)
		else $error("timeout missing");
	a_to_free: assert property (p_to_free)
		else $error("sda held in timeout");
	a_to_clear: assert property (p_to_clear)
		else $error("timeout left without start");
	a_ack_steady: assert property (p_ack_steady)
		else $error("sda drive moved with scl high");
	c_hs: cover property ($rose(hs_mode_out));
	c_to: cover property ($rose(timeout_out));
	c_ack: cover property ($rose(sda_d_oe));
endmodule

// ===== test/i2c_slave_bus_conditions_tb.sv
// self-checking bench: master and target joined over the link
`timescale 1ns/1ns
module i2c_slave_bus_conditions_tb;
	localparam int         TO = 2000;
	localparam logic [6:0] AL = i2c_cond_pkg::ADDR_LOW;
	localparam logic [6:0] AG = i2c_cond_pkg::ADDR_GENERAL;
	logic        clk_in;
	logic        rst_in;
	logic        cmd_valid;
	logic [9:0]  cmd;
	logic        cmd_ready;
	logic        done;
	logic        acked;
	logic [7:0]  rd_data;
	logic        pin;
	logic [15:0] reg_word;
	logic [7:0]  ptr;
	logic        wr_valid;
	logic [7:0]  wr_data;
	logic        wr_ready;
	logic        hs;
	logic        tmo;
	int          err_total;
	int          cmp_count;
	i2c_cond_if i2c_cond_if_i ();
	i2c_master i2c_master_i (.clk_in(clk_in), .rst_in(rst_in), .bus(i2c_cond_if_i.master),
		.cmd_valid_in(cmd_valid), .cmd_in(cmd), .cmd_ready_out(cmd_ready),
		.done_out(done), .acked_out(acked), .rd_data_out(rd_data));
	i2c_target #(.TIMEOUT_CYC(TO)) i2c_target_i (.clk_in(clk_in), .rst_in(rst_in),
		.bus(i2c_cond_if_i.target), .address_select_pin_in(pin), .reg_word_in(reg_word),
		.pointer_out(ptr), .wr_valid_out(wr_valid), .wr_data_out(wr_data),
		.wr_ready_in(wr_ready), .hs_mode_out(hs), .timeout_out(tmo));
	i2c_cond_asserts #(.TIMEOUT_CYC(TO)) i2c_cond_asserts_i (.clk_in(clk_in),
		.rst_in(rst_in), .scl(i2c_cond_if_i.scl), .sda(i2c_cond_if_i.sda),
		.sda_d_oe(i2c_cond_if_i.sda_d_oe), .hs_mode_out(hs), .timeout_out(tmo));
	// clock
	initial begin
		clk_in = 1'h0;
		forever #5 clk_in = ~clk_in;
	end
	// counts, verdict, end of run
	task automatic conclude;
		$display("compares %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// bit compare
	task automatic chk_b(input logic g, input logic e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("Error at %0t got %h exp %h", $time, g, e);
		end
	endtask
	// byte compare
	task automatic chk_y(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("Error at %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one command into the master, wait for its byte to finish
	task automatic xfer(input logic [9:0] c);
		int n;
		@(negedge clk_in);
		cmd_valid = 1'h1;
		cmd = c;
		for (n = 0; n < 500 && cmd_ready !== 1'h1; n++) @(negedge clk_in);
		if (n == 500) begin
			err_total++;
			conclude();
		end
		@(negedge clk_in);
		cmd_valid = 1'h0;
		for (n = 0; n < 4000 && done !== 1'h1; n++) @(negedge clk_in);
		if (n == 4000) begin
			err_total++;
			conclude();
		end
	endtask
	// idle lines and reset values
	task automatic sc_reset;
		chk_b(i2c_cond_if_i.sda, 1'h1);
		chk_b(i2c_cond_if_i.scl, 1'h1);
		chk_y(ptr, i2c_cond_pkg::PTR_TEMP);
		chk_b(hs, 1'h0);
	endtask
	// strap picks the address, foreign address refused
	task automatic sc_addr;
		for (int p = 0; p < 2; p++) begin
			pin = 1'(p);
			xfer({2'h3, AL, 1'h0});
			chk_b(acked, p == 0);
			xfer({2'h3, i2c_cond_pkg::ADDR_HIGH, 1'h0});
			chk_b(acked, p == 1);
		end
		xfer({2'h3, 7'h50, 1'h0});
		chk_b(acked, 1'h0);
		pin = 1'h0;
	endtask
	// pointer then several data bytes
	task automatic sc_write;
		xfer({2'h2, AL, 1'h0});
		chk_b(acked, 1'h1);
		xfer({2'h0, 8'h03});
		chk_y(ptr, 8'h03);
		for (int i = 0; i < 3; i++) begin
			xfer({1'h0, i == 2, 8'(8'hC0 + i)});
			chk_b(acked, 1'h1);
			chk_b(wr_valid, 1'h1);
			chk_y(wr_data, 8'(8'hC0 + i));
			@(negedge clk_in);
			wr_ready = 1'h1;
			@(negedge clk_in);
			wr_ready = 1'h0;
		end
	endtask
	// word read, ended by nack and stop
	task automatic rd_word(input logic [6:0] a);
		xfer({2'h2, a, 1'h1});
		chk_b(acked, 1'h1);
		xfer({2'h0, 8'hFF});
		chk_y(rd_data, reg_word[15:8]);
		xfer({2'h1, 8'hFF});
		chk_y(rd_data, reg_word[7:0]);
	endtask
	// reads, general call read, short read
	task automatic sc_read;
		reg_word = 16'h5A3C;
		rd_word(AL);
		rd_word(AG);
		xfer({2'h2, AL, 1'h1});
		xfer({2'h1, 8'hFF});
		chk_y(rd_data, 8'h5A);
		reg_word = 16'hC3A5;
		rd_word(AL);
		chk_y(ptr, 8'h03);
	endtask
	// general call write
	task automatic sc_gcall;
		xfer({2'h2, AG, 1'h0});
		chk_b(acked, 1'h1);
		xfer({2'h0, 8'h06});
		chk_b(acked, 1'h1);
		chk_b(wr_valid, 1'h0);
		xfer({2'h1, 8'h11});
		chk_b(acked, 1'h0);
		chk_y(ptr, 8'h03);
	endtask
	// every high-speed code, repeated start, stop
	task automatic sc_hs;
		for (int i = 0; i < 8; i++) begin
			xfer({2'h2, i2c_cond_pkg::HS_PATTERN, 3'(i)});
			chk_b(acked, 1'h0);
			chk_b(hs, 1'h1);
			xfer({2'h2, AL, 1'h0});
			chk_b(acked, 1'h1);
			chk_b(hs, 1'h1);
			xfer({2'h1, 8'h03});
			for (int n = 0; n < 60 && hs !== 1'h0; n++) @(negedge clk_in);
			chk_b(hs, 1'h0);
		end
	endtask
	// stall with sda held low, then fresh start
	task automatic sc_timeout;
		reg_word = 16'h1234;
		xfer({2'h2, AL, 1'h1});
		xfer({2'h0, 8'hFF});
		for (int n = 0; n < 100 && i2c_cond_if_i.sda !== 1'h0; n++) @(negedge clk_in);
		chk_b(i2c_cond_if_i.sda, 1'h0);
		for (int n = 0; n < TO + 200 && tmo !== 1'h1; n++) @(negedge clk_in);
		chk_b(tmo, 1'h1);
		chk_b(i2c_cond_if_i.sda, 1'h1);
		xfer({2'h3, AL, 1'h0});
		chk_b(acked, 1'h1);
		chk_b(tmo, 1'h0);
	endtask
	// main sequence
	initial begin
		rst_in = 1'h1;
		cmd_valid = 1'h0;
		cmd = 10'h000;
		pin = 1'h0;
		reg_word = 16'h0000;
		wr_ready = 1'h0;
		repeat (12) @(negedge clk_in);
		rst_in = 1'h0;
		sc_reset();
		sc_addr();
		sc_write();
		sc_read();
		sc_gcall();
		sc_hs();
		sc_timeout();
		conclude();
	end
endmodule
